// ---- pkg/twd_pkg.sv ----
package twd_pkg;
	// ==========================================================
	// opcodes
	localparam logic [7:0] OP_TEST_A = 8'h4d;
	localparam logic [7:0] OP_TEST_B = 8'h5d;
	localparam logic [7:0] OP_TEST_EXT = 8'h7d;
	localparam logic [7:0] OP_TEST_IDX = 8'h6d;
	localparam logic [7:0] OP_PAGE_Y = 8'h18;
	localparam logic [7:0] OP_WAIT = 8'h3e;
	localparam logic [7:0] OP_XFER_CCR = 8'h06;
	// ==========================================================
	// ccr bit positions
	localparam int CCR_C = 0;
	localparam int CCR_V = 1;
	localparam int CCR_Z = 2;
	localparam int CCR_N = 3;
	localparam int CCR_X = 6;
	localparam logic [7:0] CCR_RESET = 8'hd0;
	// ==========================================================
	// timing counts
	localparam logic [4:0] WAIT_STACK_CYC = 5'h0c;
	localparam logic [4:0] WAIT_VEC_CYC = 5'h02;
	localparam logic [4:0] TEST_INH_CYC = 5'h02;
	localparam logic [4:0] TEST_EXT_CYC = 5'h06;
	localparam logic [4:0] TEST_IX_CYC = 5'h06;
	localparam logic [4:0] TEST_IY_CYC = 5'h07;
	// operand formats
	typedef enum logic [2:0] {
		twd_opnd_direct,
		twd_opnd_indexed,
		twd_opnd_extended,
		twd_opnd_imm8,
		twd_opnd_imm16,
		twd_opnd_relative,
		twd_opnd_mask
	} twd_opnd_t;
endpackage : twd_pkg

// ---- pkg/twd_opnd_if.sv ----
`timescale 1ns/10ps
// operand formation request and result between core and address unit
interface twd_opnd_if;
	import twd_pkg::*;
	twd_opnd_t kind;
	logic [7:0] byte_hi;
	logic [7:0] byte_lo;
	logic use_y;
	logic [15:0] index_one;
	logic [15:0] index_two;
	logic [15:0] next_pc;
	logic [7:0] mask_target;
	logic [15:0] addr;
	logic [7:0] masked;
	modport core (output kind, byte_hi, byte_lo, use_y, index_one, index_two,
		next_pc, mask_target, input addr, masked);
	modport unit (input kind, byte_hi, byte_lo, use_y, index_one, index_two,
		next_pc, mask_target, output addr, masked);
endinterface : twd_opnd_if

// ---- hdl/twd_opnd_unit.sv ----
`timescale 1ns/10ps
// operand byte to address / data former, registered result
module twd_opnd_unit (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// operand request
	twd_opnd_if.unit op
);
	import twd_pkg::*;
	logic [15:0] next_addr;
	logic [7:0] next_masked;
	// ==========================================================
	// form address for each operand kind
	always_comb begin
		next_masked = op.mask_target & op.byte_lo;
		case (op.kind)
			twd_opnd_direct: next_addr = {8'h00, op.byte_lo};
			twd_opnd_indexed: next_addr = (op.use_y ? op.index_two : op.index_one)
				+ {8'h00, op.byte_lo};
			twd_opnd_extended: next_addr = {op.byte_hi, op.byte_lo};
			twd_opnd_imm16: next_addr = {op.byte_hi, op.byte_lo};
			twd_opnd_imm8: next_addr = {8'h00, op.byte_lo};
			twd_opnd_relative: next_addr = op.next_pc
				+ {{8{op.byte_lo[7]}}, op.byte_lo};
			default: next_addr = {8'h00, op.byte_lo};
		endcase
	end
	// register results so data leaves from flip-flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			op.addr <= 16'h0000;
			op.masked <= 8'h00;
		end else begin
			op.addr <= next_addr;
			op.masked <= next_masked;
		end
	end
	a_direct_page: assert property (@(posedge clk) disable iff (rst)
		op.kind == twd_opnd_direct |=> op.addr[15:8] == 8'h00)
		else $error("direct address left page zero");
	a_relative_sum: assert property (@(posedge clk) disable iff (rst)
		op.kind == twd_opnd_relative |=> op.addr == $past(op.next_pc)
		+ {{8{$past(op.byte_lo[7])}}, $past(op.byte_lo)})
		else $error("relative target wrong");
	a_mask_only: assert property (@(posedge clk) disable iff (rst)
		1'b1 |=> (op.masked & ~$past(op.byte_lo)) == 8'h00)
		else $error("unmasked bit affected");
	a_ext_order: assert property (@(posedge clk) disable iff (rst)
		op.kind == twd_opnd_extended |=> op.addr[15:8] == $past(op.byte_hi))
		else $error("extended high byte misplaced");
	a_idx_sum: assert property (@(posedge clk) disable iff (rst)
		op.kind == twd_opnd_indexed && !op.use_y
		|=> op.addr == $past(op.index_one) + {8'h00, $past(op.byte_lo)})
		else $error("indexed address wrong");
endmodule : twd_opnd_unit

// ---- hdl/twd_core.sv ----
`timescale 1ns/10ps
// test / wait / operand slice of the cpu core
module twd_core (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// program memory bytes, one per cycle while fetch_req
	input wire logic [7:0] mem_data,
	output logic fetch_req,
	output logic [15:0] mem_addr,
	// interrupt line, from outside the clock domain
	input wire logic irq_pin,
	// operand formation request, from the instruction sequencer
	input wire logic opnd_start,
	input wire twd_pkg::twd_opnd_t opnd_kind,
	input wire logic opnd_use_y,
	input wire logic [7:0] opnd_mask_target,
	// cpu state
	input wire logic [7:0] acc_a,
	input wire logic [7:0] acc_b,
	input wire logic [15:0] index_register_one,
	input wire logic [15:0] index_register_two,
	output logic [7:0] ccr,
	// status
	output logic stacking,
	output logic waiting,
	output logic vector_fetch,
	output logic busy,
	output logic [15:0] opnd_addr,
	output logic [7:0] opnd_masked,
	output logic opnd_done
);
	import twd_pkg::*;
	typedef enum {st_fetch, st_page, st_hi, st_lo, st_exec, st_stack, st_wait,
		st_vector} twd_state_t;
	twd_state_t state, next_state;
	logic [15:0] pc, next_pc;
	logic [7:0] opc, next_opc;
	logic [7:0] hi, next_hi;
	logic [7:0] lo, next_lo;
	logic [7:0] next_ccr;
	logic [4:0] cnt, next_cnt;
	logic [4:0] len, next_len;
	logic page_y, next_page_y;
	logic irq_s1, irq_s2;
	logic [7:0] tval;
	logic onded, next_onded;
	twd_opnd_if opif ();
	// ==========================================================
	// interrupt pin synchroniser, two flops
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_s1 <= 1'b0;
			irq_s2 <= 1'b0;
		end else begin
			irq_s1 <= irq_pin;
			irq_s2 <= irq_s1;
		end
	end
	// ==========================================================
	// operand former shared by all addressing modes
	// memory tests reuse the former: indexed form adds the index, others take the byte pair
	assign opif.kind = opnd_start ? opnd_kind
		: (opc == OP_TEST_IDX) ? twd_opnd_indexed : twd_opnd_extended;
	assign opif.byte_hi = hi;
	assign opif.byte_lo = opnd_start ? mem_data : lo;
	assign opif.use_y = opnd_start ? opnd_use_y : page_y;
	assign opif.index_one = index_register_one;
	assign opif.index_two = index_register_two;
	assign opif.next_pc = pc;
	assign opif.mask_target = opnd_mask_target;
	twd_opnd_unit u_opnd (
		.clk(clk),
		.rst(rst),
		.op(opif.unit)
	);
	assign opnd_addr = opif.addr;
	assign opnd_masked = opif.masked;
	// ==========================================================
	// value tested: accumulator or memory byte returned for memory forms
	always_comb begin
		case (opc)
			OP_TEST_A: tval = acc_a;
			OP_TEST_B: tval = acc_b;
			default: tval = mem_data;
		endcase
	end
	// sequencer next-state; cnt counts cycles from the opcode fetch, or from zero on leaving wait for the vector fetch
	always_comb begin
		next_state = state;
		next_pc = pc;
		next_opc = opc;
		next_hi = hi;
		next_lo = lo;
		next_ccr = ccr;
		next_cnt = cnt + 5'h01;
		next_len = len;
		next_page_y = page_y;
		next_onded = opnd_start;
		case (state)
			st_fetch: begin
				next_cnt = 5'h01;
				next_pc = pc + 16'h0001;
				next_opc = mem_data;
				next_page_y = 1'b0;
				if (mem_data == OP_PAGE_Y) begin
					next_state = st_page;
				end else if (mem_data == OP_WAIT) begin
					next_state = st_stack;
				end else if (mem_data == OP_TEST_EXT) begin
					next_len = TEST_EXT_CYC;
					next_state = st_hi;
				end else if (mem_data == OP_TEST_IDX) begin
					next_len = TEST_IX_CYC;
					next_state = st_lo;
				end else begin
					next_len = TEST_INH_CYC;
					next_state = st_exec;
				end
			end
			st_page: begin
				next_pc = pc + 16'h0001;
				next_opc = mem_data;
				next_page_y = 1'b1;
				next_len = TEST_IY_CYC;
				next_state = (mem_data == OP_TEST_IDX) ? st_lo : st_exec;
			end
			st_hi: begin
				next_pc = pc + 16'h0001;
				next_hi = mem_data; // high byte first
				next_state = st_lo;
			end
			st_lo: begin
				next_pc = pc + 16'h0001;
				next_lo = mem_data;
				next_state = st_exec;
			end
			st_exec: begin
				if (cnt >= len - 5'h01) begin
					if (opc == OP_TEST_A || opc == OP_TEST_B || opc == OP_TEST_EXT
						|| opc == OP_TEST_IDX) begin
						next_ccr[CCR_N] = tval[7];
						next_ccr[CCR_Z] = (tval == 8'h00);
						next_ccr[CCR_V] = 1'b0;
						next_ccr[CCR_C] = 1'b0;
					end else if (opc == OP_XFER_CCR) begin
						// clear allowed, set blocked on the nmi mask
						next_ccr = acc_a;
						next_ccr[CCR_X] = ccr[CCR_X] & acc_a[CCR_X];
					end
					next_state = st_fetch;
				end
			end
			st_stack: begin
				if (cnt == WAIT_STACK_CYC - 5'h01) begin
					next_state = st_wait;
				end
			end
			st_wait: begin
				next_cnt = 5'h00;
				if (irq_s2) begin
					next_state = st_vector;
				end
			end
			st_vector: begin
				if (cnt == WAIT_VEC_CYC - 5'h01) begin
					next_state = st_fetch;
				end
			end
			default: next_state = st_fetch;
		endcase
	end
	// sequencer registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= st_fetch;
			pc <= 16'h0000;
			opc <= 8'h00;
			hi <= 8'h00;
			lo <= 8'h00;
			ccr <= CCR_RESET;
			cnt <= 5'h00;
			len <= 5'h00;
			page_y <= 1'b0;
			onded <= 1'b0;
		end else begin
			state <= next_state;
			pc <= next_pc;
			opc <= next_opc;
			hi <= next_hi;
			lo <= next_lo;
			ccr <= next_ccr;
			cnt <= next_cnt;
			len <= next_len;
			page_y <= next_page_y;
			onded <= next_onded;
		end
	end
	// ==========================================================
	// bus and status outputs
	assign fetch_req = (state == st_fetch) || (state == st_page) || (state == st_hi)
		|| (state == st_lo);
	assign mem_addr = (state == st_exec && (opc == OP_TEST_EXT || opc == OP_TEST_IDX))
		? opif.addr : pc;
	assign stacking = (state == st_stack);
	assign waiting = (state == st_wait);
	assign vector_fetch = (state == st_vector);
	assign busy = (state != st_fetch);
	assign opnd_done = onded;
	// ==========================================================
	// run length of stacking, so its length is checked without a long repetition
	logic [4:0] stack_run, next_stack_run;
	always_comb begin
		next_stack_run = stacking ? stack_run + 5'h01 : 5'h00;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stack_run <= 5'h00;
		end else begin
			stack_run <= next_stack_run;
		end
	end
	// ==========================================================
	// checks
	a_test_clears_vc: assert property (@(posedge clk) disable iff (rst)
		state == st_exec && next_state == st_fetch && opc == OP_TEST_A
		|=> !ccr[CCR_V] && !ccr[CCR_C] && ccr[CCR_Z] == ($past(acc_a) == 8'h00))
		else $error("test of a gave wrong flags");
	a_test_b_len: assert property (@(posedge clk) disable iff (rst)
		state == st_fetch && mem_data == OP_TEST_B |=> state == st_exec ##1
		state == st_fetch)
		else $error("test of b not two cycles");
	a_wait_start: assert property (@(posedge clk) disable iff (rst)
		state == st_fetch && mem_data == OP_WAIT |=> stacking && stack_run == 5'h00)
		else $error("stacking did not follow wait opcode");
	a_wait_stack_len: assert property (@(posedge clk) disable iff (rst)
		waiting && !$past(waiting) |-> stack_run == WAIT_STACK_CYC - 5'h01)
		else $error("stacking not twelve cycles");
	a_wait_hold: assert property (@(posedge clk) disable iff (rst)
		waiting && !irq_s2 |=> waiting)
		else $error("left wait without interrupt");
	a_vector_len: assert property (@(posedge clk) disable iff (rst)
		waiting && irq_s2 |=> vector_fetch ##1 vector_fetch ##1 state == st_fetch)
		else $error("vector fetch not two cycles");
	a_nmi_no_set: assert property (@(posedge clk) disable iff (rst)
		!ccr[CCR_X] |=> !ccr[CCR_X])
		else $error("nmi mask became set");
	a_ext_hi_first: assert property (@(posedge clk) disable iff (rst)
		state == st_hi |=> state == st_lo && hi == $past(mem_data))
		else $error("extended high byte not first");
	c_wait_full: cover property (@(posedge clk) disable iff (rst) vector_fetch ##2 !busy);
	c_test_ext: cover property (@(posedge clk) disable iff (rst)
		state == st_exec && opc == OP_TEST_EXT);
	c_test_iy: cover property (@(posedge clk) disable iff (rst) page_y && state == st_exec);
	c_relative: cover property (@(posedge clk) disable iff (rst)
		opnd_start && opnd_kind == twd_opnd_relative);
endmodule : twd_core

// ---- dv/twd_mem_model.sv ----
`timescale 1ns/10ps
// program memory beside the core, combinational read
module twd_mem_model (
	// fetch side
	input wire logic [15:0] addr,
	output logic [7:0] data,
	// bench byte, used only while the core sits idle
	input wire logic ovr_en,
	input wire logic [7:0] ovr_data
);
	logic [7:0] mem [0:65535];
	// =========================================
	// fill with an unused opcode so stray fetches run as short no-ops
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h01;
		end
	end
	// read path
	assign data = ovr_en ? ovr_data : mem[addr];
endmodule : twd_mem_model

// ---- dv/tb_cpu_test_wait_operand_decode.sv ----
`timescale 1ns/10ps
module tb_cpu_test_wait_operand_decode;
	import twd_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] mem_data, ccr, opnd_masked, acc_a = 8'h00, acc_b = 8'h00;
	logic [15:0] mem_addr, opnd_addr, index_register_one = 16'h0000;
	logic [15:0] index_register_two = 16'h0000;
	logic fetch_req, stacking, waiting, vector_fetch, busy, opnd_done;
	logic irq_pin = 1'b0, opnd_start = 1'b0, opnd_use_y = 1'b0, ovr_en = 1'b0;
	logic [7:0] opnd_mask_target = 8'h00, ovr_data = 8'h00, exp_ccr = CCR_RESET;
	twd_opnd_t opnd_kind = twd_opnd_direct;
	logic [31:0] lfsr = 32'h00012880;
	logic [15:0] pc = 16'h0010;
	logic [7:0] ext_hi = 8'h00;
	int failures = 0;
	int tests_run = 0;
	// =========================================
	// clock and units
	always #50 clk = ~clk;
	twd_core i_twd_core (.clk(clk), .rst(rst), .mem_data(mem_data), .fetch_req(fetch_req),
		.mem_addr(mem_addr), .irq_pin(irq_pin), .opnd_start(opnd_start),
		.opnd_kind(opnd_kind), .opnd_use_y(opnd_use_y), .opnd_mask_target(opnd_mask_target),
		.acc_a(acc_a), .acc_b(acc_b), .index_register_one(index_register_one),
		.index_register_two(index_register_two), .ccr(ccr), .stacking(stacking),
		.waiting(waiting), .vector_fetch(vector_fetch), .busy(busy), .opnd_addr(opnd_addr),
		.opnd_masked(opnd_masked), .opnd_done(opnd_done));
	twd_mem_model i_twd_mem_model (.addr(mem_addr), .data(mem_data), .ovr_en(ovr_en),
		.ovr_data(ovr_data));
	// =========================================
	// eight shifts per draw so successive bytes are not simple shifts of each other
	function automatic logic [7:0] rnd();
		for (int i = 0; i < 8; i++) begin
			lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		end
		return lfsr[7:0];
	endfunction : rnd
	// flags after a zero-or-minus test of v
	function automatic logic [7:0] tst(input logic [7:0] c, input logic [7:0] v);
		logic [7:0] r;
		r = c;
		r[CCR_N] = v[7];
		r[CCR_Z] = (v == 8'h00);
		r[CCR_V] = 1'b0;
		r[CCR_C] = 1'b0;
		return r;
	endfunction : tst
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic end_sim();
		if (failures == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	// stop at the negedge before the edge that takes the opcode at pc
	task automatic sync_fetch();
		int k;
		k = 0;
		@(negedge clk);
		while (!(fetch_req === 1'b1 && busy === 1'b0 && mem_addr === pc) && k < 200) begin
			@(negedge clk);
			k++;
		end
		check("fetch sync", 16'(k / 200), 16'h0000);
	endtask : sync_fetch
	// ops are spaced by eight no-ops so the next one is written well ahead of the core
	task automatic do_op(input logic [23:0] code, input int len, input int cyc,
		input logic [7:0] exp);
		for (int i = 0; i < len; i++) begin
			i_twd_mem_model.mem[pc + 16'(i)] = code[23 - 8 * i -: 8];
		end
		sync_fetch();
		repeat (cyc - 1) @(negedge clk);
		check("ccr early", {8'h00, ccr}, {8'h00, exp_ccr});
		@(negedge clk);
		check("ccr", {8'h00, ccr}, {8'h00, exp});
		exp_ccr = exp;
		pc = pc + 16'(len) + 16'h0008;
	endtask : do_op
	// every operand kind, issued while the core is parked
	task automatic opnd_tests();
		logic [7:0] b;
		twd_opnd_t k;
		for (int t = 0; t < 21; t++) begin
			k = twd_opnd_t'(t % 7);
			b = (t < 7) ? 8'h7f : (t < 14) ? 8'h80 : rnd();
			@(posedge clk);
			opnd_start <= 1'b1;
			opnd_kind <= k;
			opnd_use_y <= b[0];
			opnd_mask_target <= rnd();
			ovr_en <= 1'b1;
			ovr_data <= b;
			@(posedge clk);
			opnd_start <= 1'b0;
			ovr_en <= 1'b0;
			@(negedge clk);
			check("opnd done", {15'h0000, opnd_done}, 16'h0001);
			case (k)
				twd_opnd_direct: check("direct", opnd_addr, {8'h00, b});
				twd_opnd_indexed: check("indexed", opnd_addr, (b[0] ? index_register_two :
					index_register_one) + {8'h00, b});
				twd_opnd_relative: check("relative", opnd_addr,
					pc + 16'h0001 + {{8{b[7]}}, b});
				twd_opnd_mask: check("mask", {8'h00, opnd_masked}, {8'h00, opnd_mask_target & b});
				twd_opnd_imm8: check("imm8", opnd_addr, {8'h00, b});
				twd_opnd_imm16: check("imm16", opnd_addr, {ext_hi, b});
				default: check("extended", opnd_addr, {ext_hi, b});
			endcase
		end
	endtask : opnd_tests
	// =========================================
	// watchdog, far beyond the expected run of about thirteen hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		end_sim();
	end
	// main sequence
	initial begin
		logic [7:0] v, r, off;
		logic [15:0] a, ea;
		int sel;
		repeat (4) @(posedge clk);
		check("ccr reset", {8'h00, ccr}, {8'h00, CCR_RESET});
		rst <= 1'b0;
		for (int t = 0; t < 30; t++) begin
			sel = t % 5;
			v = (t < 5) ? 8'h00 : (t < 10) ? 8'h80 : rnd();
			r = rnd() | 8'h03;
			r[6] = r[6] & (t != 7);
			off = rnd();
			a = {8'h80 | (rnd() & 8'h3e), rnd()};
			ea = (sel == 2) ? a : ((sel == 4) ? a ^ 16'h0100 : a) + {8'h00, off};
			i_twd_mem_model.mem[ea] = v;
			@(posedge clk);
			acc_a <= r;
			index_register_one <= a;
			index_register_two <= a ^ 16'h0100;
			do_op({OP_XFER_CCR, 16'h0000}, 1, 2, {r[7], r[6] & exp_ccr[6], r[5:0]});
			@(posedge clk);
			acc_a <= v;
			acc_b <= ~v;
			case (sel)
				0: do_op({OP_TEST_A, 16'h0000}, 1, TEST_INH_CYC, tst(exp_ccr, v));
				1: do_op({OP_TEST_B, 16'h0000}, 1, TEST_INH_CYC, tst(exp_ccr, ~v));
				2: begin
					ext_hi = a[15:8];
					do_op({OP_TEST_EXT, a}, 3, TEST_EXT_CYC, tst(exp_ccr, v));
				end
				3: do_op({OP_TEST_IDX, off, 8'h00}, 2, TEST_IX_CYC, tst(exp_ccr, v));
				default: do_op({OP_PAGE_Y, OP_TEST_IDX, off}, 3, TEST_IY_CYC, tst(exp_ccr, v));
			endcase
		end
		i_twd_mem_model.mem[pc] = OP_WAIT;
		sync_fetch();
		fork
			begin
				int tot, stk, wt, vf;
				tot = 0;
				stk = 0;
				wt = 0;
				vf = 0;
				@(negedge clk);
				while (!(fetch_req === 1'b1 && busy === 1'b0) && tot < 300) begin
					tot++;
					stk += int'(stacking);
					wt += int'(waiting);
					vf += int'(vector_fetch);
					@(negedge clk);
				end
				check("stack cycles", 16'(stk + 1), 16'(WAIT_STACK_CYC));
				check("vector cycles", 16'(vf), 16'(WAIT_VEC_CYC));
				check("wait length", 16'(tot + 1), 16'(14 + wt));
				check("ccr after wait", {8'h00, ccr}, {8'h00, exp_ccr});
			end
			begin
				repeat (14) @(posedge clk);
				opnd_tests();
				repeat (rnd() & 8'h07) @(posedge clk);
				irq_pin <= 1'b1;
				repeat (8) @(posedge clk);
				irq_pin <= 1'b0;
			end
		join
		end_sim();
	end
endmodule : tb_cpu_test_wait_operand_decode
